/* src/acrb_regbank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acrb_cfg.svh"
module acrb_regbank
  import acrb_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5a // arbitrary value
) (
  input wire logic sys_clk, // 20 MHz clock
  input wire logic reset_n, // async active-low reset
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // data drive level, always low
  output logic sda_oe, // high while pulling data low
  input wire logic addr_select, // low bit of target address
  input wire acrb_sample_t sample_in, // converted sample, 12 bits per axis
  input wire logic sample_strobe, // one-cycle pulse per sample-rate period
  output logic operate_enable, // main control operate bit
  output logic resolution_select, // main control resolution bit
  output logic [7:0] sample_rate // output rate control register
);
  logic rst_meta_q;
  logic rst_sync_q;
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_q;
  logic sda_q;
  acrb_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] pointer_q;
  logic reading_q;
  logic ack_pending_q;
  logic [7:0] main_ctrl_q;
  logic [7:0] sec_ctrl_q;
  logic [7:0] int_ctrl_a_q;
  logic [7:0] int_ctrl_b_q;
  logic [7:0] rate_ctrl_q;
  logic [7:0] wake_timer_q;
  logic [7:0] stim_ctrl_q;
  logic [7:0] wake_thresh_q;
  acrb_sample_t out_q;
  acrb_sample_t held_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;
  logic busy_read;
  logic byte_done;
  logic [7:0] rd_byte;

  // reset release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // pins pass three flops; a change counts once the last two agree
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
    end
  end

  always_comb begin
    scl_rise = scl_sync_q[1] & scl_sync_q[2] & ~scl_q;
    scl_fall = ~scl_sync_q[1] & ~scl_sync_q[2] & scl_q;
    start_cond = scl_q & scl_sync_q[2] & sda_q & ~sda_sync_q[1] & ~sda_sync_q[2];
    stop_cond = scl_q & scl_sync_q[2] & ~sda_q & sda_sync_q[1] & sda_sync_q[2];
    addr_match = (shift_q[7:1] == {`ACRB_TARGET_FIXED, addr_select});
    busy_read = (state_q != ACRB_IDLE) && reading_q;
    byte_done = (bit_cnt_q == 4'h8);
  end

  function automatic logic [7:0] read_reg(input logic [7:0] a, input acrb_sample_t s);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `ACRB_X_LOW: r = {s.x[3:0], 4'h0};
      `ACRB_X_HIGH: r = s.x[11:4];
      `ACRB_Y_LOW: r = {s.y[3:0], 4'h0};
      `ACRB_Y_HIGH: r = s.y[11:4];
      `ACRB_Z_LOW: r = {s.z[3:0], 4'h0};
      `ACRB_Z_HIGH: r = s.z[11:4];
      `ACRB_SELFTEST_RESP: r = `ACRB_SELFTEST_IDLE;
      `ACRB_IDENTITY: r = IDENTITY_VALUE;
      `ACRB_MAIN_CTRL: r = main_ctrl_q;
      `ACRB_SEC_CTRL: r = sec_ctrl_q;
      `ACRB_INT_CTRL_A: r = int_ctrl_a_q;
      `ACRB_INT_CTRL_B: r = int_ctrl_b_q;
      `ACRB_RATE_CTRL: r = rate_ctrl_q;
      `ACRB_WAKE_TIMER: r = wake_timer_q;
      `ACRB_STIM_CTRL: r = stim_ctrl_q;
      `ACRB_WAKE_THRESH: r = wake_thresh_q;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] next_pointer(input logic [7:0] p);
    return p + 8'h01;
  endfunction

  // byte handed out next; the frozen copy while a read runs
  always_comb begin
    rd_byte = read_reg(pointer_q, busy_read ? held_q : out_q);
  end

  // protocol engine; bits sampled on scl rise, sda changed on scl fall
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ACRB_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      reading_q <= 1'b0;
      ack_pending_q <= 1'b0;
    end else if (start_cond) begin
      state_q <= ACRB_ADDR;
      bit_cnt_q <= 4'h0;
      reading_q <= 1'b0;
    end else if (stop_cond) begin
      state_q <= ACRB_IDLE;
    end else if (scl_rise) begin
      unique case (state_q)
        ACRB_ADDR, ACRB_PTR, ACRB_WDATA: begin
          shift_q <= {shift_q[6:0], sda_q};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        ACRB_RDATA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        ACRB_MACK: begin
          // master nack ends the burst; an ack reloads on the next fall
          if (sda_q) begin
            state_q <= ACRB_IDLE;
          end
        end
        ACRB_SACK, ACRB_IDLE: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        ACRB_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              reading_q <= shift_q[0];
              ack_pending_q <= shift_q[0];
              state_q <= ACRB_SACK;
            end else begin
              state_q <= ACRB_IDLE;
            end
          end
        end
        ACRB_PTR, ACRB_WDATA: begin
          if (byte_done) begin
            state_q <= ACRB_SACK;
          end
        end
        ACRB_RDATA: begin
          if (byte_done) begin
            state_q <= ACRB_MACK;
          end else begin
            shift_q <= {shift_q[6:0], 1'b0};
          end
        end
        ACRB_SACK: begin
          bit_cnt_q <= 4'h0;
          if (reading_q) begin
            shift_q <= rd_byte;
            state_q <= ACRB_RDATA;
          end else begin
            state_q <= ack_pending_q ? ACRB_WDATA : ACRB_PTR;
            ack_pending_q <= 1'b1;
          end
        end
        ACRB_MACK: begin
          bit_cnt_q <= 4'h0;
          shift_q <= rd_byte;
          state_q <= ACRB_RDATA;
        end
        ACRB_IDLE: ;
      endcase
    end
  end

  // data pull is the output flop itself, so it settles inside the scl low phase
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sda_oe <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_q)
        ACRB_ADDR: begin
          if (byte_done) begin
            sda_oe <= addr_match;
          end
        end
        ACRB_PTR, ACRB_WDATA: begin
          if (byte_done) begin
            sda_oe <= 1'b1;
          end
        end
        ACRB_RDATA: begin
          // bit 7 already went out at the ack fall, so bit 6 follows
          sda_oe <= byte_done ? 1'b0 : ~shift_q[6];
        end
        ACRB_SACK, ACRB_MACK: begin
          sda_oe <= reading_q ? ~rd_byte[7] : 1'b0;
        end
        ACRB_IDLE: ;
      endcase
    end
  end

  // pointer moves once per byte, after its ack slot opens
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pointer_q <= 8'h00;
    end else if (scl_fall && byte_done) begin
      unique case (state_q)
        ACRB_PTR: begin
          pointer_q <= {1'b0, shift_q[6:0]};
        end
        ACRB_WDATA: begin
          pointer_q <= next_pointer(pointer_q);
        end
        ACRB_RDATA: begin
          pointer_q <= next_pointer(pointer_q);
        end
        ACRB_IDLE, ACRB_ADDR, ACRB_SACK, ACRB_MACK: ;
      endcase
    end
  end

  // register writes land in the ack cycle of each data byte
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      main_ctrl_q <= `ACRB_CTRL_RESET;
      sec_ctrl_q <= `ACRB_CTRL_RESET;
      int_ctrl_a_q <= `ACRB_CTRL_RESET;
      int_ctrl_b_q <= `ACRB_CTRL_RESET;
      rate_ctrl_q <= `ACRB_CTRL_RESET;
      wake_timer_q <= `ACRB_CTRL_RESET;
      stim_ctrl_q <= `ACRB_CTRL_RESET;
      wake_thresh_q <= `ACRB_CTRL_RESET;
    end else if (scl_fall && state_q == ACRB_WDATA && bit_cnt_q == 4'h8) begin
      unique case (pointer_q)
        `ACRB_MAIN_CTRL: main_ctrl_q <= shift_q;
        `ACRB_SEC_CTRL: sec_ctrl_q <= shift_q;
        `ACRB_INT_CTRL_A: int_ctrl_a_q <= shift_q;
        `ACRB_INT_CTRL_B: int_ctrl_b_q <= shift_q;
        `ACRB_RATE_CTRL: rate_ctrl_q <= shift_q;
        `ACRB_WAKE_TIMER: wake_timer_q <= shift_q;
        `ACRB_STIM_CTRL: stim_ctrl_q <= shift_q;
        `ACRB_WAKE_THRESH: wake_thresh_q <= shift_q;
        default: ;
      endcase
    end
  end

  // sample capture; 8-bit mode keeps only the top byte, low nibble read as zero
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      out_q <= '0;
    end else if (sample_strobe && main_ctrl_q[`ACRB_OPERATE_BIT]) begin
      if (main_ctrl_q[`ACRB_RES_BIT]) begin
        out_q <= sample_in;
      end else begin
        out_q.x <= {sample_in.x[11:4], 4'h0};
        out_q.y <= {sample_in.y[11:4], 4'h0};
        out_q.z <= {sample_in.z[11:4], 4'h0};
      end
    end
  end

  // snapshot frozen for a whole read so bytes stay consistent
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      held_q <= '0;
    end else if (!busy_read) begin
      held_q <= out_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sda_out <= 1'b0;
      operate_enable <= 1'b0;
      resolution_select <= 1'b0;
      sample_rate <= 8'h00;
    end else begin
      sda_out <= 1'b0;
      operate_enable <= main_ctrl_q[`ACRB_OPERATE_BIT];
      resolution_select <= main_ctrl_q[`ACRB_RES_BIT];
      sample_rate <= rate_ctrl_q;
    end
  end
endmodule // acrb_regbank
`default_nettype wire

/* pkg/acrb_cfg.svh */
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH
// register offsets
`define ACRB_X_LOW 8'h06
`define ACRB_X_HIGH 8'h07
`define ACRB_Y_LOW 8'h08
`define ACRB_Y_HIGH 8'h09
`define ACRB_Z_LOW 8'h0a
`define ACRB_Z_HIGH 8'h0b
`define ACRB_SELFTEST_RESP 8'h0c
`define ACRB_IDENTITY 8'h0f
`define ACRB_INT_SRC_PRI 8'h16
`define ACRB_INT_SRC_AXIS 8'h17
`define ACRB_INT_SUMMARY 8'h18
`define ACRB_INT_RELEASE 8'h1a
`define ACRB_MAIN_CTRL 8'h1b
`define ACRB_SEC_CTRL 8'h1d
`define ACRB_INT_CTRL_A 8'h1e
`define ACRB_INT_CTRL_B 8'h1f
`define ACRB_RATE_CTRL 8'h21
`define ACRB_WAKE_TIMER 8'h29
`define ACRB_STIM_CTRL 8'h3a
`define ACRB_WAKE_THRESH 8'h6a
// field positions and reset values
`define ACRB_OPERATE_BIT 7
`define ACRB_RES_BIT 6
`define ACRB_CTRL_RESET 8'h00
`define ACRB_SELFTEST_IDLE 8'h55
// fixed upper six bits of the target address
`define ACRB_TARGET_FIXED 6'h07
`endif

/* pkg/acrb_pkg.sv */
package acrb_pkg;
  typedef enum logic [2:0] {
    ACRB_IDLE = 3'b000,
    ACRB_ADDR = 3'b001,
    ACRB_PTR = 3'b010,
    ACRB_WDATA = 3'b011,
    ACRB_RDATA = 3'b100,
    ACRB_MACK = 3'b101,
    ACRB_SACK = 3'b110
  } acrb_state_t;
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } acrb_sample_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } acrb_bus_t;
endpackage

/* verification/acrb_regbank_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module acrb_regbank_assertions
  import acrb_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic reset_n, // reset
  input wire logic scl_in, // bus clock
  input wire logic sda_in, // bus data
  input wire logic sda_out, // drive level
  input wire logic sda_oe, // pull enable
  input wire logic addr_select, // address bit
  input wire acrb_sample_t sample_in, // sample
  input wire logic sample_strobe, // sample pulse
  input wire logic operate_enable, // operate bit
  input wire logic resolution_select, // resolution bit
  input wire logic [7:0] sample_rate // rate register
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // cycles since the bus clock last moved
  logic [5:0] quiet_q;
  // unknown until the first edge, so the reset check skips time zero
  logic seen_q;
  always_ff @(posedge sys_clk) begin
    seen_q <= 1'b1;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 6'h3f;
    end else if ($changed(scl_in)) begin
      quiet_q <= 6'h00;
    end else if (quiet_q != 6'h3f) begin
      quiet_q <= quiet_q + 6'h01;
    end
  end
  a_drive_low: assert property (sda_out == 1'b0)
    else $error("data drive level not low");
  a_oe_holds_high: assert property ($rose(scl_in) |-> ##1 $stable(sda_oe) [*3])
    else $error("data pull moved while bus clock high");
  a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data pull moved outside bus clock low");
  a_idle_released: assert property (quiet_q > 6'd20 |-> !sda_oe)
    else $error("data pulled on an idle bus");
  a_start_free: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe)
    else $error("device pulling data at a start");
  a_reg_quiet: assert property
    ($changed({operate_enable, resolution_select, sample_rate}) |-> quiet_q < 6'd12)
    else $error("register changed without bus traffic");
  a_reset_clear: assert property (disable iff (1'b0)
    seen_q && !reset_n |-> !operate_enable && !resolution_select && sample_rate == 8'h00)
    else $error("control outputs not cleared in reset");
  a_wake_quiet: assert property ($rose(reset_n) |-> !sda_oe [*3])
    else $error("data pulled right after reset");
endmodule // acrb_regbank_assertions
bind acrb_regbank acrb_regbank_assertions u_acrb_regbank_assertions (
  .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_select(addr_select),
  .sample_in(sample_in), .sample_strobe(sample_strobe), .operate_enable(operate_enable),
  .resolution_select(resolution_select), .sample_rate(sample_rate)
);
`default_nettype wire

/* verification/acrb_master.sv */
`timescale 1ns/1ps
`default_nettype none
module acrb_master (
  output logic scl, // bus clock, still between frames
  output logic pull, // high while pulling data low
  input wire logic sda // resolved data line
);
  // 400 ns bus clock; whole device cycles keep edges on the falling clock
  localparam int TL = 250;
  localparam int TH = 150;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    pull = 1'b0;
    #TL scl = 1'b1;
    #TH pull = 1'b1;
    #TH scl = 1'b0;
  endtask
  // msb first, ninth bit is the ack slot
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      pull = !o[k];
      #TL scl = 1'b1;
      #TH i[k] = sda;
      scl = 1'b0;
    end
  endtask
  task automatic stop();
    pull = 1'b1;
    #TL scl = 1'b1;
    #TH pull = 1'b0;
    #TH;
  endtask
endmodule // acrb_master
`default_nettype wire

/* verification/acrb_regbank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module acrb_regbank_bench;
  import acrb_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // arbitrary
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic addr_select = 1'b0;
  logic sample_strobe = 1'b0;
  acrb_sample_t sample_in = '0;
  logic scl;
  logic pull;
  logic sda_oe;
  logic operate_enable;
  logic resolution_select;
  logic [7:0] sample_rate;
  wire logic sda;
  int mismatches = 0;
  int n_checks = 0;
  integer seed = 32'hb7d4;
  logic [6:0] sa;
  assign sda = !(sda_oe | pull);
  always #25 sys_clk = !sys_clk;
  acrb_regbank #(.IDENTITY_VALUE(ID)) u_acrb_regbank (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .addr_select(addr_select), .sample_in(sample_in),
    .sample_strobe(sample_strobe), .operate_enable(operate_enable),
    .resolution_select(resolution_select), .sample_rate(sample_rate));
  acrb_master u_acrb_master (.scl(scl), .pull(pull), .sda(sda));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic pulse(input acrb_sample_t s);
    @(negedge sys_clk);
    sample_in = s;
    sample_strobe = 1'b1;
    @(negedge sys_clk);
    sample_strobe = 1'b0;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic [8:0] i;
    u_acrb_master.start();
    u_acrb_master.xfer({sa, 1'b0, 1'b1}, i);
    check("write addr ack", {7'h00, i[0]}, 8'h00);
    u_acrb_master.xfer({ptr, 1'b1}, i);
    check("pointer ack", {7'h00, i[0]}, 8'h00);
    foreach (d[k]) begin
      u_acrb_master.xfer({d[k], 1'b1}, i);
      check("data ack", {7'h00, i[0]}, 8'h00);
    end
    u_acrb_master.stop();
  endtask
  // a new sample t lands after byte number hit
  task automatic rd(input logic [7:0] ptr, input int n, input int hit, input acrb_sample_t t,
      output logic [7:0] q[$]);
    logic [8:0] i;
    q = {};
    u_acrb_master.start();
    u_acrb_master.xfer({sa, 1'b0, 1'b1}, i);
    u_acrb_master.xfer({ptr, 1'b1}, i);
    u_acrb_master.start();
    u_acrb_master.xfer({sa, 1'b1, 1'b1}, i);
    check("read addr ack", {7'h00, i[0]}, 8'h00);
    for (int k = 0; k < n; k++) begin
      u_acrb_master.xfer({8'hff, k == n - 1}, i);
      q.push_back(i[8:1]);
      if (k == hit) begin
        pulse(t);
      end
    end
    u_acrb_master.stop();
  endtask
  function automatic logic [7:0] exp_b(input acrb_sample_t s, input int k, input logic res);
    logic [11:0] v;
    v = k < 2 ? s.x : (k < 4 ? s.y : s.z);
    if (!res) begin
      v[3:0] = 4'h0;
    end
    return k[0] ? v[11:4] : {v[3:0], 4'h0};
  endfunction
  initial begin
    logic [8:0] i;
    logic [31:0] r;
    logic [7:0] q[$];
    acrb_sample_t s;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    r = $random(seed);
    addr_select = r[0];
    reset_n = 1'b1;
    sa = {6'h07, r[0]};
    repeat (8) @(negedge sys_clk);
    u_acrb_master.start();
    u_acrb_master.xfer({sa ^ 7'h01, 1'b0, 1'b1}, i);
    check("foreign addr", {7'h00, i[0]}, 8'h01);
    u_acrb_master.stop();
    r = $random(seed);
    wr(8'h1d, {r[7:0], r[15:8], r[23:16]});
    wr(8'h21, {r[31:24]});
    check("rate port", sample_rate, r[31:24]);
    rd(8'h1d, 3, 9, s, q);
    for (int k = 0; k < 3; k++) begin
      check("control", q[k], r[8*k+:8]);
    end
    wr(8'h0e, {8'hff, 8'h33, 8'h44});
    rd(8'h0c, 5, 9, s, q);
    check("selftest", q[0], 8'h55);
    check("reserved", q[1], 8'h00);
    check("identity", q[3], ID);
    check("reserved", q[4], 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(8'h1b, {8'h00});
      wr(8'h1b, {(m == 0) ? 8'hc0 : 8'h80});
      check("mode", {6'h00, operate_enable, resolution_select}, 8'h03 - m[7:0]);
      r = $random(seed);
      s = acrb_sample_t'(m ? 36'({r, r}) : {12'h800, 12'h7ff, 12'hfff});
      pulse(s);
      rd(8'h06, 6, 0, ~s, q);
      for (int k = 0; k < 6; k++) begin
        check("held sample", q[k], exp_b(s, k, m == 0));
      end
      rd(8'h06, 6, 9, s, q);
      for (int k = 0; k < 6; k++) begin
        check("new sample", q[k], exp_b(~s, k, m == 0));
      end
    end
    final_report();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
endmodule // acrb_regbank_bench
`default_nettype wire
